// ===== core/charge_seq_pkg.sv
// constants and types for the charge sequencing and safety timer block
package charge_seq_pkg;
    // operating modes
    typedef enum logic [1:0] {
        MODE_CHARGE,
        MODE_BOOST,
        MODE_HIZ
    } op_mode_t;

    // charge phases
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SHORT,
        PH_RAMP,
        PH_TAPER,
        PH_DONE,
        PH_OFF
    } phase_t;

    // status code field values
    localparam logic [2:0] STAT_READY = 3'h0;
    localparam logic [2:0] STAT_CHARGING = 3'h1;
    localparam logic [2:0] STAT_DONE = 3'h2;
    localparam logic [2:0] STAT_FAULT = 3'h3;

    // current and voltage codes (mA / mV)
    localparam int CUR_W = 12;
    localparam int VOLT_W = 13;
    localparam logic [11:0] INPUT_LIMIT_RST = 12'h064;   // 100 mA
    localparam logic [11:0] FAST_CHARGE_RST = 12'h0fa;   // 250 mA
    localparam logic [11:0] TERM_CURRENT_RST = 12'h032;  // 50 mA
    localparam logic [12:0] REG_VOLT_MIN = 13'h0dac;     // 3500 mV
    localparam logic [12:0] REG_VOLT_MAX = 13'h1158;     // 4440 mV
    localparam logic [12:0] REG_VOLT_RST = 13'h0dd4;     // 3540 mV
    localparam logic [12:0] RECHARGE_OFFSET = 13'h0078;  // 120 mV
    localparam logic [11:0] RAMP_STEP_RST = 12'h001;     // mA per ramp tick
    localparam logic TERM_ENABLE_RST = 1'b0;

    // timing
    localparam longint CLK_HZ = 125000000;
    localparam longint LONG_TIMER_S = 1920;              // 32 minutes
    localparam longint SHORT_TIMER_S = 32;
    localparam longint TICK_HZ = 1000;                   // divided reference
    localparam longint TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam longint LONG_TICKS = LONG_TIMER_S * TICK_HZ;
    localparam longint SHORT_TICKS = SHORT_TIMER_S * TICK_HZ;
    localparam int RAMP_TICK_CYCLES = 125;               // 1 us slew step
endpackage

// ===== core/charge_seq.sv
// charge sequencing with two-stage safety timer for a one-cell charger
//
// Overview of operation
// [R1] three modes: charge, boost, high impedance
// [R2] high impedance: no charge, no boost
// [R3] below short threshold apply short current only
// [R4] above short: ramp current toward limit
// [R5] input limit defaults 100 mA, host programmable
// [R6] regulation voltage programmable 3.5 to 4.44 V
// [R7] terminate at termination current above recharge level
// [R8] termination disabled when enable bit is 0
// [R9] recharge, weak-battery power-up, enable toggle restart
// [R10] charge start runs long timer; writes stop it
// [R11] long timer stopped starts short timer
// [R12] kick restarts short timer, bit self-clears
// [R13] short expiry: stop, defaults, long timer, resume
// [R14] long expiry: charger off, fault code
// [R15] timer fault latched until power-on reset
// [R16] status held until host reads it
// [R17] thermal shutdown freezes timers, stops switching
// [R18] timers count divided reference, counts parameterised
// [R19] kick reads 0 idle; no double start
`timescale 1ns/1ps
module charge_seq #(
    parameter longint TICK_CYCLES = charge_seq_pkg::TICK_CYCLES,
    parameter longint LONG_TICKS = charge_seq_pkg::LONG_TICKS,
    parameter longint SHORT_TICKS = charge_seq_pkg::SHORT_TICKS,
    parameter bit AUTO_CHARGE = 1'b1
) (
    input wire logic sys_clk, // 125 MHz clock
    input wire logic nrst, // sync reset, active low (supply power-on reset)
    input wire logic host_write, // one-cycle pulse per host register write
    input wire logic status_read, // one-cycle pulse: host read status
    input wire logic boost_req, // host boost mode bit
    input wire logic hiz_req, // host high impedance bit
    input wire logic charge_enable, // host charger enable bit
    input wire logic charge_reset, // pulse: host reset bit written
    input wire logic term_enable, // host termination enable bit
    input wire logic kick_write, // pulse: host writes 1 to safety_timer_kick
    input wire logic limit_write, // pulse: load input_current_limit
    input wire logic [11:0] limit_in, // new input_current_limit, mA
    input wire logic fast_write, // pulse: load fast-charge current
    input wire logic [11:0] fast_in, // new fast-charge current, mA
    input wire logic term_write, // pulse: load termination_current
    input wire logic [11:0] term_in, // new termination_current, mA
    input wire logic volt_write, // pulse: load regulation_voltage
    input wire logic [12:0] volt_in, // new regulation_voltage, mV
    input wire logic [12:0] bat_mv, // battery voltage from monitor, mV
    input wire logic [11:0] chg_ma, // measured charge current, mA
    input wire logic bat_short, // battery below short threshold (pin)
    input wire logic bat_weak, // battery below weak_battery_threshold (pin)
    input wire logic thermal_sd, // thermal shutdown (pin)
    output logic [1:0] op_mode, // active mode, op_mode_t
    output logic switching_en, // pwm stage enable
    output logic short_current_en, // fixed short-circuit current source
    output logic boost_en, // boost stage enable
    output logic low_power, // high impedance low draw
    output logic [11:0] charge_target, // ramped charge current target, mA
    output logic [11:0] input_current_limit, // active input limit, mA
    output logic [12:0] regulation_voltage, // active regulation voltage, mV
    output logic [11:0] termination_current, // active termination level, mA
    output logic [2:0] status_code_field, // reported status code
    output logic safety_timer_kick, // kick bit readback
    output logic timer_fault, // latched safety timer fault
    output logic long_timer_run, // long_safety_timer running
    output logic short_timer_run // short_keepalive_timer running
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // a zero count would wrap the compare value to all ones, the longest possible timeout
    if (TICK_CYCLES < 1 || LONG_TICKS < 1 || SHORT_TICKS < 1) begin
        $error("timer counts must be at least one");
    end
    // divider and timers count in 32-bit registers
    if (TICK_CYCLES > 64'hffff_ffff || LONG_TICKS > 64'hffff_ffff) begin
        $error("timer counts exceed the 32-bit counters");
    end
    if (SHORT_TICKS > 64'hffff_ffff) begin
        $error("short timer count exceeds the 32-bit counter");
    end
    // the slew divider is 8 bits wide
    if (charge_seq_pkg::RAMP_TICK_CYCLES < 1 || charge_seq_pkg::RAMP_TICK_CYCLES > 256) begin
        $error("ramp tick count does not fit the slew divider");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // pins are asynchronous: two flops before any logic
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    always_ff @(posedge sys_clk) begin
        pin_s1_reg <= {thermal_sd, bat_weak, bat_short};
        pin_s2_reg <= pin_s1_reg;
    end
    wire short_s = pin_s2_reg[0];
    wire weak_s = pin_s2_reg[1];
    wire hot_s = pin_s2_reg[2];

    // ------------------------------------------------------------
    // charge parameters
    // ------------------------------------------------------------
    logic [11:0] limit_reg;
    logic [11:0] fast_reg;
    logic [11:0] term_reg;
    logic [12:0] volt_reg;
    logic term_en_reg;
    logic defaults_load;
    // out-of-range writes pulled to the nearest end
    wire [12:0] volt_clamped = (volt_in < charge_seq_pkg::REG_VOLT_MIN) ?
        charge_seq_pkg::REG_VOLT_MIN : (volt_in > charge_seq_pkg::REG_VOLT_MAX) ?
        charge_seq_pkg::REG_VOLT_MAX : volt_in;
    // short timer expiry restores every default
    always_ff @(posedge sys_clk) begin
        if (!nrst || defaults_load) begin
            limit_reg <= charge_seq_pkg::INPUT_LIMIT_RST; // [R5] [R13]
            fast_reg <= charge_seq_pkg::FAST_CHARGE_RST;
            term_reg <= charge_seq_pkg::TERM_CURRENT_RST;
            volt_reg <= charge_seq_pkg::REG_VOLT_RST;
            term_en_reg <= charge_seq_pkg::TERM_ENABLE_RST;
        end else begin
            if (limit_write) limit_reg <= limit_in; // [R5]
            if (fast_write) fast_reg <= fast_in; // [R5]
            if (term_write) term_reg <= term_in;
            if (volt_write) volt_reg <= volt_clamped; // [R6]
            if (host_write) term_en_reg <= term_enable; // [R8]
        end
    end
    assign input_current_limit = limit_reg;
    assign regulation_voltage = volt_reg;
    assign termination_current = term_reg;

    // ------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------
    charge_seq_pkg::op_mode_t mode_next;
    charge_seq_pkg::op_mode_t mode_reg;
    // high impedance outranks boost
    assign mode_next = hiz_req ? charge_seq_pkg::MODE_HIZ :
        boost_req ? charge_seq_pkg::MODE_BOOST : charge_seq_pkg::MODE_CHARGE; // [R1]
    always_ff @(posedge sys_clk) begin
        if (!nrst) mode_reg <= charge_seq_pkg::MODE_HIZ;
        else mode_reg <= mode_next;
    end
    wire in_charge = (mode_reg == charge_seq_pkg::MODE_CHARGE);
    assign op_mode = mode_reg;

    // ------------------------------------------------------------
    // reference tick divider
    // ------------------------------------------------------------
    // one reference tick drives both safety timers
    logic [31:0] div_reg;
    wire tick = (div_reg == 32'(TICK_CYCLES - 1));
    always_ff @(posedge sys_clk) begin
        if (!nrst || tick) div_reg <= 32'h0;
        else div_reg <= div_reg + 32'h1; // [R18]
    end
    // separate slew step divider for the current ramp
    logic [7:0] ramp_div_reg;
    wire ramp_tick = (ramp_div_reg == 8'(charge_seq_pkg::RAMP_TICK_CYCLES - 1));
    always_ff @(posedge sys_clk) begin
        if (!nrst || ramp_tick) ramp_div_reg <= 8'h0;
        else ramp_div_reg <= ramp_div_reg + 8'h1;
    end

    // ------------------------------------------------------------
    // phase decoding
    // ------------------------------------------------------------
    // phases in which current flows into the battery
    function automatic logic phase_active(input charge_seq_pkg::phase_t ph);
        return (ph == charge_seq_pkg::PH_SHORT) || (ph == charge_seq_pkg::PH_RAMP) ||
            (ph == charge_seq_pkg::PH_TAPER);
    endfunction
    // phases in which the pwm stage regulates the current
    function automatic logic phase_pwm(input charge_seq_pkg::phase_t ph);
        return (ph == charge_seq_pkg::PH_RAMP) || (ph == charge_seq_pkg::PH_TAPER);
    endfunction

    // ------------------------------------------------------------
    // charge phase machine
    // ------------------------------------------------------------
    charge_seq_pkg::phase_t phase_reg;
    charge_seq_pkg::phase_t phase_next;
    logic fault_reg;
    logic en_prev_reg;
    logic por_seen_reg;
    logic short_expire;
    logic long_expire;
    wire en_toggle = en_prev_reg != charge_enable;
    wire [12:0] recharge_mv = volt_reg - charge_seq_pkg::RECHARGE_OFFSET;
    wire recharge_hit = bat_mv < recharge_mv; // [R9]
    // weak-battery start fires once, on the first released cycle
    wire por_start = !por_seen_reg && AUTO_CHARGE && weak_s; // [R9]
    wire restart = charge_reset || (en_toggle && charge_enable) || por_start; // [R9]
    wire term_hit = term_en_reg && (chg_ma <= term_reg) && !recharge_hit; // [R7] [R8]
    // the power-up start overrides the host bits
    wire may_charge = (in_charge || por_start) && (charge_enable || por_start)
        && !fault_reg;
    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            charge_seq_pkg::PH_IDLE: begin
                if (may_charge) phase_next = charge_seq_pkg::PH_SHORT;
            end
            charge_seq_pkg::PH_SHORT: begin
                if (!short_s) phase_next = charge_seq_pkg::PH_RAMP; // [R3]
            end
            charge_seq_pkg::PH_RAMP: begin
                if (short_s) phase_next = charge_seq_pkg::PH_SHORT;
                else if (bat_mv >= volt_reg) phase_next = charge_seq_pkg::PH_TAPER;
            end
            charge_seq_pkg::PH_TAPER: begin
                if (term_hit) phase_next = charge_seq_pkg::PH_DONE; // [R7]
                else if (bat_mv < volt_reg) phase_next = charge_seq_pkg::PH_RAMP;
            end
            charge_seq_pkg::PH_DONE: begin
                if (recharge_hit) phase_next = charge_seq_pkg::PH_SHORT; // [R9]
            end
            charge_seq_pkg::PH_OFF: begin
                phase_next = charge_seq_pkg::PH_OFF; // [R14]
            end
        endcase
        if (phase_reg != charge_seq_pkg::PH_OFF) begin
            if (long_expire) phase_next = charge_seq_pkg::PH_OFF; // [R14]
            else if (!may_charge) phase_next = charge_seq_pkg::PH_IDLE; // [R2]
            else if (restart || short_expire) phase_next = charge_seq_pkg::PH_SHORT; // [R13]
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            phase_reg <= charge_seq_pkg::PH_IDLE;
            en_prev_reg <= 1'b0;
            por_seen_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            en_prev_reg <= charge_enable;
            por_seen_reg <= 1'b1;
        end
    end
    wire charging = phase_active(phase_reg);
    // entry to precharge from a stopped phase
    wire start_charge = charging == 1'b0 && phase_next == charge_seq_pkg::PH_SHORT;

    // ------------------------------------------------------------
    // current ramp
    // ------------------------------------------------------------
    logic [11:0] target_reg;
    wire [11:0] ceiling = (fast_reg < limit_reg) ? fast_reg : limit_reg;
    // taper keeps the ramped level; the voltage loop trims the current
    wire ramp_up = (phase_reg == charge_seq_pkg::PH_RAMP) && ramp_tick && !hot_s &&
        (target_reg < ceiling);
    always_ff @(posedge sys_clk) begin
        if (!nrst || !phase_pwm(phase_reg)) begin
            target_reg <= 12'h0;
        end else if (ramp_up) begin
            target_reg <= target_reg + charge_seq_pkg::RAMP_STEP_RST; // [R4]
        end else if (target_reg > ceiling) begin
            target_reg <= ceiling; // [R4]
        end
    end
    assign charge_target = target_reg;
    assign short_current_en = (phase_reg == charge_seq_pkg::PH_SHORT) && !hot_s; // [R3]
    assign switching_en = !hot_s && ((in_charge && phase_pwm(phase_reg)) || boost_en); // [R17]
    assign boost_en = (mode_reg == charge_seq_pkg::MODE_BOOST) && !hot_s; // [R1]
    assign low_power = (mode_reg == charge_seq_pkg::MODE_HIZ); // [R2]

    // ------------------------------------------------------------
    // safety timers
    // ------------------------------------------------------------
    logic long_run_reg;
    logic short_run_reg;
    logic kick_reg;
    logic [31:0] long_cnt_reg;
    logic [31:0] short_cnt_reg;
    wire tmr_tick = tick && !hot_s; // [R17]
    assign long_expire = long_run_reg && tmr_tick && long_cnt_reg == 32'(LONG_TICKS - 1);
    // a pending kick blocks short expiry in its own cycle
    assign short_expire = short_run_reg && tmr_tick &&
        short_cnt_reg == 32'(SHORT_TICKS - 1) && !kick_reg;
    assign defaults_load = short_expire; // [R13]
    // expiry and fault outrank a host write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            long_run_reg <= 1'b0;
            short_run_reg <= 1'b0;
            long_cnt_reg <= 32'h0;
            short_cnt_reg <= 32'h0;
        end else if (long_expire || fault_reg) begin
            long_run_reg <= 1'b0;
            short_run_reg <= 1'b0;
        end else if (short_expire) begin
            short_run_reg <= 1'b0; // [R13]
            long_run_reg <= 1'b1;
            long_cnt_reg <= 32'h0;
        end else if (long_run_reg && host_write) begin
            long_run_reg <= 1'b0; // [R10]
            short_run_reg <= 1'b1; // [R11] [R19]
            short_cnt_reg <= 32'h0;
        end else if (start_charge && !short_run_reg) begin
            long_run_reg <= 1'b1; // [R10]
            long_cnt_reg <= 32'h0;
        end else begin
            if (short_run_reg && kick_reg) short_cnt_reg <= 32'h0; // [R12]
            else if (short_run_reg && tmr_tick) short_cnt_reg <= short_cnt_reg + 32'h1;
            if (long_run_reg && tmr_tick) long_cnt_reg <= long_cnt_reg + 32'h1; // [R18]
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) kick_reg <= 1'b0;
        else if (kick_write) kick_reg <= 1'b1; // [R12]
        else kick_reg <= 1'b0; // [R12] [R19]
    end
    assign safety_timer_kick = kick_reg;
    assign long_timer_run = long_run_reg;
    assign short_timer_run = short_run_reg;

    // ------------------------------------------------------------
    // fault latch and status
    // ------------------------------------------------------------
    // only reset clears the timer fault
    always_ff @(posedge sys_clk) begin
        if (!nrst) fault_reg <= 1'b0;
        else if (long_expire) fault_reg <= 1'b1; // [R14] [R15]
    end
    assign timer_fault = fault_reg;
    logic [2:0] stat_reg;
    logic stat_unread_reg;
    logic [2:0] stat_now;
    assign stat_now = fault_reg || long_expire ? charge_seq_pkg::STAT_FAULT :
        charging ? charge_seq_pkg::STAT_CHARGING :
        (phase_reg == charge_seq_pkg::PH_DONE) ? charge_seq_pkg::STAT_DONE :
        charge_seq_pkg::STAT_READY;
    // a read in the cycle of a change lets the new code through
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            stat_reg <= charge_seq_pkg::STAT_READY;
            stat_unread_reg <= 1'b0;
        end else if (stat_now != stat_reg && (!stat_unread_reg || status_read)) begin
            stat_reg <= stat_now; // [R16] [R14]
            stat_unread_reg <= 1'b1;
        end else if (status_read) begin
            stat_unread_reg <= 1'b0; // [R16]
        end
    end
    assign status_code_field = stat_reg;
endmodule

// ===== tb/charge_seq_chk.sv
// port-level assertions for the charge sequencing block
`timescale 1ns/1ps
module charge_seq_chk (
    input wire logic sys_clk, // clock
    input wire logic nrst, // sync reset, active low
    input wire logic host_write, // host write pulse
    input wire logic status_read, // status read pulse
    input wire logic kick_write, // kick write pulse
    input wire logic limit_write, // limit load pulse
    input wire logic [11:0] limit_in, // new limit
    input wire logic thermal_sd, // thermal shutdown pin
    input wire logic [1:0] op_mode, // active mode
    input wire logic switching_en, // pwm enable
    input wire logic boost_en, // boost enable
    input wire logic low_power, // low draw
    input wire logic [11:0] charge_target, // ramp target
    input wire logic [11:0] input_current_limit, // active limit
    input wire logic [12:0] regulation_voltage, // active voltage
    input wire logic [2:0] status_code_field, // status
    input wire logic safety_timer_kick, // kick readback
    input wire logic timer_fault, // latched fault
    input wire logic long_timer_run, // long timer running
    input wire logic short_timer_run // short timer running
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    mode_legal_a: assert property (op_mode != 2'h3)
        else $error("illegal operating mode");
    hiz_quiet_a: assert property (op_mode == charge_seq_pkg::MODE_HIZ |->
        !switching_en && !boost_en && low_power) else $error("hiz not quiet");
    ramp_slew_a: assert property (charge_target > $past(charge_target) |->
        charge_target == $past(charge_target) + 12'h001) else $error("ramp jump");
    limit_load_a: assert property (limit_write |=> input_current_limit == $past(limit_in))
        else $error("limit not loaded");
    volt_range_a: assert property (regulation_voltage >= charge_seq_pkg::REG_VOLT_MIN &&
        regulation_voltage <= charge_seq_pkg::REG_VOLT_MAX) else $error("volt range");
    write_stops_long_a: assert property (host_write && long_timer_run |=>
        !long_timer_run && short_timer_run) else $error("long timer kept");
    timers_exclusive_a: assert property (!(long_timer_run && short_timer_run))
        else $error("both timers run");
    kick_pulse_a: assert property (kick_write |=> safety_timer_kick ##1 !safety_timer_kick)
        else $error("kick bit not one pulse");
    fault_off_a: assert property (timer_fault |-> !switching_en)
        else $error("switching in fault");
    fault_sticky_a: assert property (timer_fault |=> timer_fault)
        else $error("fault cleared");
    fault_read_a: assert property (status_read && timer_fault |=>
        status_code_field == charge_seq_pkg::STAT_FAULT) else $error("fault unseen");
    thermal_stop_a: assert property (thermal_sd [*3] |-> !switching_en)
        else $error("switching in shutdown");
    kick_c: cover property (kick_write ##2 short_timer_run);
    expiry_c: cover property (short_timer_run ##1 long_timer_run);
    fault_c: cover property ($rose(timer_fault));
endmodule
bind charge_seq charge_seq_chk chk_u (.sys_clk, .nrst, .host_write, .status_read,
    .kick_write, .limit_write, .limit_in, .thermal_sd, .op_mode, .switching_en, .boost_en,
    .low_power, .charge_target, .input_current_limit, .regulation_voltage,
    .status_code_field, .safety_timer_kick, .timer_fault, .long_timer_run, .short_timer_run);

// ===== tb/host_model.sv
// host side: register write and status read strobes
`timescale 1ns/1ps
module host_model (
    input wire logic sys_clk, // clock
    output logic host_write, // any write
    output logic status_read, // status read
    output logic kick_write, // kick write
    output logic limit_write, // limit load
    output logic fast_write, // fast load
    output logic term_write, // term load
    output logic volt_write, // volt load
    output logic [12:0] data // shared value
);
    initial begin
        {host_write, status_read, kick_write, limit_write} = 4'h0;
        {fast_write, term_write, volt_write} = 3'h0;
        data = 13'h0000;
    end
    // one write, sel 0 limit 1 fast 2 term 3 volt 4 kick 5 plain
    task automatic wr(input int sel, input logic [12:0] val);
        @(posedge sys_clk) #1;
        host_write = 1'b1;
        data = val;
        limit_write = (sel == 0);
        fast_write = (sel == 1);
        term_write = (sel == 2);
        volt_write = (sel == 3);
        kick_write = (sel == 4);
        @(posedge sys_clk) #1;
        {host_write, limit_write, fast_write, term_write, volt_write, kick_write} = 6'h00;
        data = ~val;
    endtask
    task automatic rd();
        @(posedge sys_clk) #1;
        status_read = 1'b1;
        @(posedge sys_clk) #1;
        status_read = 1'b0;
    endtask
endmodule

// ===== tb/charge_sequence_safety_timer_tb_top.sv
// self-checking bench for the charge sequencing block
`timescale 1ns/1ps
module charge_sequence_safety_timer_tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic boost_req = 1'b0, hiz_req = 1'b0, charge_enable = 1'b1, charge_reset = 1'b0;
    logic term_enable = 1'b1, bat_short = 1'b1, bat_weak = 1'b1, thermal_sd = 1'b0;
    logic [12:0] bat_mv = 13'h0e74;
    logic [11:0] chg_ma = 12'h1f4;
    logic hw, sr, kw, lw, fw, tw, vw;
    logic [12:0] hd;
    logic [1:0] op_mode;
    logic sw_en, sc_en, lp, ben, kick, fault, lrun, srun;
    logic [11:0] limit, term, target;
    logic [12:0] volt;
    logic [2:0] stat;
    int fail_count = 0, check_count = 0, cycles = 0, model_limit, model_volt;
    logic [12:0] v;
    initial forever #4 sys_clk = ~sys_clk;
    host_model host_u (.sys_clk(sys_clk), .host_write(hw), .status_read(sr), .kick_write(kw),
        .limit_write(lw), .fast_write(fw), .term_write(tw), .volt_write(vw), .data(hd));
    charge_seq #(.TICK_CYCLES(2), .LONG_TICKS(20), .SHORT_TICKS(5)) dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .host_write(hw), .status_read(sr),
        .boost_req(boost_req), .hiz_req(hiz_req), .charge_enable(charge_enable),
        .charge_reset(charge_reset), .term_enable(term_enable), .kick_write(kw),
        .limit_write(lw), .limit_in(hd[11:0]), .fast_write(fw), .fast_in(hd[11:0]),
        .term_write(tw), .term_in(hd[11:0]), .volt_write(vw), .volt_in(hd), .bat_mv(bat_mv),
        .chg_ma(chg_ma), .bat_short(bat_short), .bat_weak(bat_weak), .thermal_sd(thermal_sd),
        .op_mode(op_mode), .switching_en(sw_en), .short_current_en(sc_en), .boost_en(ben),
        .low_power(lp), .charge_target(target), .input_current_limit(limit),
        .regulation_voltage(volt), .termination_current(term), .status_code_field(stat),
        .safety_timer_kick(kick), .timer_fault(fault), .long_timer_run(lrun),
        .short_timer_run(srun));
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_for(ref logic sig, input int limit_cycles);
        int n;
        n = 0;
        while (sig !== 1'b1 && n < limit_cycles) begin
            @(posedge sys_clk) #1;
            n++;
        end
        check(sig, 1'b1);
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(62));
        repeat (20) @(posedge sys_clk);
        #1 nrst = 1'b1;
        model_limit = charge_seq_pkg::INPUT_LIMIT_RST;
        model_volt = charge_seq_pkg::REG_VOLT_RST;
        check(limit, model_limit);
        check(volt, model_volt);
        check(term, charge_seq_pkg::TERM_CURRENT_RST);
        wait_for(lrun, 8);
        check(sc_en, 1'b1);
        check({sw_en, target}, 13'h0000);
        bat_short = 1'b0;
        host_u.wr(0, 13'h01f4);
        model_limit = 500;
        check(limit, model_limit);
        check({lrun, srun}, 2'b01);
        chg_ma = 12'h020;
        host_u.wr(4, 13'h0001);
        host_u.rd();
        check(stat, charge_seq_pkg::STAT_DONE);
        check(sw_en, 1'b0);
        chg_ma = 12'h1f4;
        charge_reset = 1'b1;
        @(posedge sys_clk) #1;
        charge_reset = 1'b0;
        check(sc_en, 1'b1);
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? 13'(3499 + i * 470) : 13'($urandom_range(3000, 4900));
            host_u.wr(3, v);
            model_volt = (v < 3500) ? 3500 : (v > 4440) ? 4440 : v;
            check(volt, model_volt);
            host_u.wr(4, 13'h0001);
            check(kick, 1'b1);
            @(posedge sys_clk) #1;
            check(kick, 1'b0);
            check(srun, 1'b1);
        end
        wait_for(lrun, 20);
        check(limit, charge_seq_pkg::INPUT_LIMIT_RST);
        check(volt, charge_seq_pkg::REG_VOLT_RST);
        thermal_sd = 1'b1;
        repeat (100) @(posedge sys_clk);
        #1 check({fault, sw_en}, 2'b00);
        thermal_sd = 1'b0;
        wait_for(fault, 80);
        check(sw_en, 1'b0);
        host_u.rd();
        check(stat, charge_seq_pkg::STAT_FAULT);
        charge_enable = 1'b0;
        host_u.wr(5, 13'h0000);
        charge_enable = 1'b1;
        host_u.wr(5, 13'h0000);
        check(fault, 1'b1);
        bat_weak = 1'b0;
        nrst = 1'b0;
        hiz_req = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check(fault, 1'b0);
        check({op_mode, lp, sw_en}, {charge_seq_pkg::MODE_HIZ, 2'b10});
        {hiz_req, boost_req} = 2'b01;
        repeat (3) @(posedge sys_clk);
        #1 check({op_mode, ben, sw_en}, {charge_seq_pkg::MODE_BOOST, 2'b11});
        wrap_up();
    end
endmodule
